// ==== rtl/bep_top.sv ====
`timescale 1ns/1ps
`include "bep_defines.svh"
// Overview of operation
// RULE1: Filter is eighth order with nine taps, index zero to eight.
// RULE2: Energy is r0*acf0 plus twice the sum of r[i]*acf[i], once per frame.
// RULE3: Encoder supplies nine autocorrelation lags summed over samples 0 to 159.
// RULE4: r[i] sums a[k]*a[k+i] for k from zero to eight minus i.
// RULE5: Second-order coefficients come from first two reflections, a0 equal one.
// RULE6: Real part is -a1/2; imaginary term is (4*a2 - a1 squared)/4.
// RULE7: Negative imaginary term means not a tone; evaluation stops.
// RULE8: Negative real part means pole above 2000 Hz; run prediction error test.
// RULE9: Both positive: ratio below 0.0973 means not a tone, else run test.
// RULE10: Energy is held as 16-bit exponent and normalized 16-bit mantissa.
// RULE11: Ratio test is done by cross multiplication, no division.
module bep_top #(
    parameter int FRAME_CYCLES = `BEP_FRAME_NS / `BEP_CLK_NS,
    parameter int ACC_W        = 58
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic                 start,
    input  wire bep_pkg::bep_frame_s  frame,
    output logic                      ready,
    output logic                      busy,
    output logic                      done,
    output bep_pkg::bep_result_s      result
);

    bep_pkg::bep_state_e      state_q;
    bep_pkg::bep_frame_s      frame_q;
    logic [31:0]              frame_cnt_q;
    logic [3:0]               lag_q;
    logic [3:0]               k_q;
    logic signed [35:0]       r_acc_q;
    logic signed [35:0]       r_acc_d;
    logic signed [19:0]       r_q [`BEP_NUM_COEF];
    logic signed [ACC_W-1:0]  e_acc_q;
    logic signed [ACC_W-1:0]  e_acc_d;
    logic [ACC_W-1:0]         norm_q;
    logic [15:0]              shift_q;
    logic                     done_q;
    bep_pkg::bep_result_s     result_q;
    logic                     take;

    // Start is honoured only when idle and a full frame has passed
    assign ready = (state_q == bep_pkg::S_IDLE) && (frame_cnt_q == 32'h0000_0000);
    assign take  = start && ready;
    assign busy  = (state_q != bep_pkg::S_IDLE);
    assign done  = done_q;
    assign result = result_q;

    // Frame pacing timer: one computation per frame period
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            frame_cnt_q <= 32'h0000_0000;
        else if (take)
            frame_cnt_q <= 32'(FRAME_CYCLES - 1); // RULE2
        else if (frame_cnt_q != 32'h0000_0000)
            frame_cnt_q <= frame_cnt_q - 32'h0000_0001;
    end

    // Capture frame so the encoder may move on at once
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            frame_q <= '0;
        else if (take)
            frame_q <= frame; // RULE3
    end

    // Coefficient autocorrelation step
    always_comb
    begin
        r_acc_d = r_acc_q + 36'(signed'(frame_q.coef[k_q]) * signed'(frame_q.coef[k_q + lag_q])); // RULE4
    end

    // Energy step; cross terms count twice
    always_comb
    begin
        // Operands widened first, else the product is cut to 32 bits
        e_acc_d = e_acc_q + ACC_W'(r_q[k_q]) * ACC_W'(signed'(frame_q.acf[k_q]))
                  * ((k_q == 4'h0) ? ACC_W'(1) : ACC_W'(2)); // RULE2
    end

    // Sequencer, one product per cycle to share a single multiplier path
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_q <= bep_pkg::S_IDLE;
            lag_q   <= 4'h0;
            k_q     <= 4'h0;
            r_acc_q <= '0;
            e_acc_q <= '0;
            norm_q  <= '0;
            shift_q <= 16'h0000;
            done_q  <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            case (state_q)
                bep_pkg::S_IDLE:
                begin
                    if (take)
                    begin
                        state_q <= bep_pkg::S_CORR;
                        lag_q   <= 4'h0;
                        k_q     <= 4'h0;
                        r_acc_q <= '0;
                        e_acc_q <= '0;
                    end
                end
                bep_pkg::S_CORR:
                begin
                    if (k_q == 4'(`BEP_LAST_IDX) - lag_q) // RULE4
                    begin
                        r_acc_q <= '0;
                        k_q     <= 4'h0;
                        if (lag_q == 4'(`BEP_LAST_IDX)) // RULE1
                            state_q <= bep_pkg::S_ENER;
                        else
                            lag_q <= lag_q + 4'h1;
                    end
                    else
                    begin
                        r_acc_q <= r_acc_d;
                        k_q     <= k_q + 4'h1;
                    end
                end
                bep_pkg::S_ENER:
                begin
                    e_acc_q <= e_acc_d;
                    if (k_q == 4'(`BEP_LAST_IDX))
                    begin
                        state_q <= bep_pkg::S_NORM;
                        shift_q <= 16'h0000;
                        // Rounding can dip slightly negative; energy clamps at zero
                        norm_q  <= e_acc_d[ACC_W-1] ? '0 : ACC_W'(e_acc_d);
                    end
                    else
                        k_q <= k_q + 4'h1;
                end
                bep_pkg::S_NORM:
                begin
                    // Shift until the top bit is set, one bit per cycle
                    if (norm_q == '0 || norm_q[ACC_W-1])
                    begin
                        state_q <= bep_pkg::S_DONE;
                    end
                    else
                    begin
                        norm_q  <= norm_q << 1; // RULE10
                        shift_q <= shift_q + 16'h0001;
                    end
                end
                bep_pkg::S_DONE:
                begin
                    state_q <= bep_pkg::S_IDLE;
                    done_q  <= 1'b1;
                end
                default:
                    state_q <= bep_pkg::S_IDLE;
            endcase
        end
    end

    // Store each finished lag, rescaled from Q30 back to Q15
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < `BEP_NUM_COEF; i++)
                r_q[i] <= '0;
        end
        else if (state_q == bep_pkg::S_CORR && k_q == 4'(`BEP_LAST_IDX) - lag_q)
            r_q[lag_q] <= 20'(r_acc_d >>> `BEP_Q_SHIFT); // RULE4
    end

    // Pole test from the captured reflections
    logic signed [15:0] rc1;
    logic signed [15:0] rc2;
    logic signed [17:0] a1;
    logic signed [35:0] a1_sq;
    logic signed [37:0] im4;
    logic signed [53:0] tone_lhs;
    logic signed [53:0] tone_rhs;
    logic               im_neg;
    logic               re_neg;

    always_comb
    begin
        rc1      = signed'(frame_q.reflection_coefs[0]);
        rc2      = signed'(frame_q.reflection_coefs[1]);
        // Full 32-bit product before rescaling to Q15
        a1       = 18'(rc1) + 18'((32'(rc1) * 32'(rc2)) >>> `BEP_Q_SHIFT); // RULE5
        a1_sq    = a1 * a1;
        im4      = (38'(rc2) <<< `BEP_A2X4_SHIFT) - 38'(a1_sq); // RULE6
        im_neg   = im4[37];
        re_neg   = !a1[17] && (a1 != 18'h0); // RULE6
        tone_lhs = 54'(im4) * 54'(`BEP_TONE_DEN); // RULE11
        tone_rhs = 54'(a1_sq) * 54'(`BEP_TONE_NUM); // RULE11
    end

    // Result register, updated only as a frame completes
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            result_q.energy_exp  <= `BEP_RST_EXP;
            result_q.energy_mant <= `BEP_RST_MANT;
            result_q.not_tone    <= 1'b0;
            result_q.run_pe_test <= 1'b0;
        end
        else if (state_q == bep_pkg::S_DONE)
        begin
            result_q.energy_exp  <= (norm_q == '0) ? 16'h0000
                                    : 16'(ACC_W) - shift_q; // RULE10
            result_q.energy_mant <= {1'b0, norm_q[ACC_W-1 -: 15]}; // RULE10
            if (im_neg)
            begin
                result_q.not_tone    <= 1'b1; // RULE7
                result_q.run_pe_test <= 1'b0;
            end
            else if (re_neg)
            begin
                result_q.not_tone    <= 1'b0; // RULE8
                result_q.run_pe_test <= 1'b1;
            end
            else
            begin
                result_q.not_tone    <= (tone_lhs < tone_rhs); // RULE9
                result_q.run_pe_test <= !(tone_lhs < tone_rhs);
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    done_single_a: assert property (done |=> !done)
        else $error("done lasted more than one cycle");
    start_latency_a: assert property (take |-> ##[57:115] done) // RULE2
        else $error("frame result not produced in time");
    pace_refuse_a: assert property (done |-> !ready) // RULE2
        else $error("new frame accepted inside frame period");
    lag_bound_a: assert property (state_q == bep_pkg::S_CORR |-> k_q + lag_q <= 4'h8) // RULE4
        else $error("coefficient index past last tap");
    mant_norm_a: assert property (done && result.energy_mant != 16'h0000
                                  |-> result.energy_mant[15:14] == 2'b01) // RULE10
        else $error("mantissa not normalized");
    zero_exp_a: assert property (done && result.energy_mant == 16'h0000
                                 |-> result.energy_exp == 16'h0000) // RULE10
        else $error("zero energy with nonzero exponent");
    im_neg_a: assert property (state_q == bep_pkg::S_DONE && im_neg |=> result.not_tone) // RULE7
        else $error("negative imaginary term not flagged");
    re_neg_a: assert property (state_q == bep_pkg::S_DONE && !im_neg && re_neg
                               |=> result.run_pe_test && !result.not_tone) // RULE8
        else $error("left half plane pole not passed on");
    verdict_excl_a: assert property (done |-> result.not_tone != result.run_pe_test) // RULE9
        else $error("tone verdict not exclusive");

    cover_low_tone_c: cover property (done && result.not_tone && !$past(im_neg, 2));
    cover_pe_c: cover property (done && result.run_pe_test);
    cover_refused_c: cover property (start && !ready && !busy);
    cover_im_neg_c: cover property (state_q == bep_pkg::S_DONE && im_neg);

endmodule // bep_top

// ==== common/bep_defines.svh ====
`ifndef BEP_DEFINES_SVH
`define BEP_DEFINES_SVH

// Filter geometry and fixed-point scaling
`define BEP_NUM_COEF   9
`define BEP_LAST_IDX   8
`define BEP_Q_SHIFT    15
// Shift taking 4*a2 from Q15 to the Q30 scale of a1 squared
`define BEP_A2X4_SHIFT 17

// Low-tone bound 0.0973 held as a ratio for cross multiplication
`define BEP_TONE_NUM   973
`define BEP_TONE_DEN   10000

// Frame pacing
`define BEP_FRAME_NS   20000000
`define BEP_CLK_NS     25

// Reset values of the result
`define BEP_RST_EXP    16'h0000
`define BEP_RST_MANT   16'h0000

`endif

// ==== common/bep_pkg.sv ====
package bep_pkg;

    // One frame of encoder data: lags 0..8, taps 0..8, first two reflections
    typedef struct packed {
        logic [8:0][31:0] acf;
        logic [8:0][15:0] coef;
        logic [1:0][15:0] reflection_coefs;
    } bep_frame_s;

    // Pseudo-float energy plus the pole verdict
    typedef struct packed {
        logic [15:0] energy_exp;
        logic [15:0] energy_mant;
        logic        not_tone;
        logic        run_pe_test;
    } bep_result_s;

    typedef enum logic [2:0] {
        S_IDLE,
        S_CORR,
        S_ENER,
        S_NORM,
        S_DONE
    } bep_state_e;

endpackage

// ==== tb/bep_enc_model.sv ====
`timescale 1ns/1ps
// Encoder side: offers one frame and holds it until the block takes it
module bep_enc_model (
    input  wire logic                sys_clk,
    input  wire logic                rst,
    input  wire logic                go,
    input  wire logic                ready,
    input  wire bep_pkg::bep_frame_s frame_in,
    output logic                     start,
    output bep_pkg::bep_frame_s      frame
);
    // Once taken the bus shows inverted junk, so a late capture is caught
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            start <= 1'b0;
            frame <= '0;
        end
        else if (start && ready)
        begin
            start <= 1'b0;
            frame <= ~frame;
        end
        else if (go && !start)
        begin
            start <= 1'b1;
            frame <= frame_in;
        end
    end
endmodule // bep_enc_model

// ==== tb/bep_top_tb.sv ====
`timescale 1ns/1ps
module bep_top_tb;
    localparam int FC = 200;
    logic                 sys_clk;
    logic                 rst;
    logic                 go;
    logic                 start;
    logic                 ready;
    logic                 busy;
    logic                 done;
    logic [31:0]          rng;
    int                   n_errors;
    int                   cmp_count;
    bep_pkg::bep_frame_s  frame_in;
    bep_pkg::bep_frame_s  frame;
    bep_pkg::bep_frame_s  f;
    bep_pkg::bep_result_s result;

    bep_top #(.FRAME_CYCLES(FC)) uut (.sys_clk(sys_clk), .rst(rst), .start(start),
        .frame(frame), .ready(ready), .busy(busy), .done(done), .result(result));
    bep_enc_model enc (.sys_clk(sys_clk), .rst(rst), .go(go), .ready(ready),
        .frame_in(frame_in), .start(start), .frame(frame));

    // 40 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    // Expected energy and pole verdict for one frame
    function automatic bep_pkg::bep_result_s expect_of(input bep_pkg::bep_frame_s x);
        bep_pkg::bep_result_s o;
        longint r, e, a1, c1, im4;
        int lz;
        e = 0;
        for (int i = 0; i < 9; i++)
        begin
            r = 0;
            for (int k = 0; k < 9 - i; k++)
                r += longint'($signed(x.coef[k])) * longint'($signed(x.coef[k + i]));
            r = r >>> 15;
            e += ((i == 0) ? 1 : 2) * r * longint'($signed(x.acf[i]));
        end
        if (e < 0)
            e = 0;
        o = '0;
        // Normalised mantissa has bit 14 set and its top bit clear
        if (e != 0)
        begin
            lz = 0;
            while (e[57] == 1'b0)
            begin
                e = e <<< 1;
                lz++;
            end
            o.energy_exp = 16'(58 - lz);
            o.energy_mant = {1'b0, e[57:43]};
        end
        c1 = longint'($signed(x.reflection_coefs[0]));
        a1 = c1 + ((c1 * longint'($signed(x.reflection_coefs[1]))) >>> 15);
        im4 = (longint'($signed(x.reflection_coefs[1])) <<< 17) - a1 * a1;
        if (im4 < 0)
            o.not_tone = 1'b1;
        else if (a1 > 0)
            o.run_pe_test = 1'b1;
        else
        begin
            o.not_tone = (10000 * im4) < (973 * a1 * a1);
            o.run_pe_test = !o.not_tone;
        end
        return o;
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // One frame: offer, wait for done, optionally wait out the pacing gap
    task automatic run(input bep_pkg::bep_frame_s x, input bit gap);
        int n;
        logic was_ready;
        frame_in = x;
        go = 1'b1;
        @(posedge sys_clk);
        #1 go = 1'b0;
        n = 0;
        // An offer made inside the pacing gap is held and must be refused
        while (busy !== 1'b1 && n < 300)
        begin
            was_ready = ready;
            @(posedge sys_clk);
            #1 n++;
            if (was_ready !== 1'b1)
                check(64'(busy), 64'h0);
        end
        if (n == 300)
        begin
            n_errors++;
            test_done();
        end
        check(64'({busy, ready}), 64'h2);
        n = 0;
        while (done !== 1'b1 && n < 300)
        begin
            @(posedge sys_clk);
            #1 n++;
        end
        if (n == 300)
        begin
            n_errors++;
            test_done();
        end
        check(64'(result), 64'(expect_of(x)));
        check(64'({ready, busy}), 64'h0);
        if (gap)
        begin
            n = 0;
            while (ready !== 1'b1 && n < 300)
            begin
                @(posedge sys_clk);
                #1 n++;
            end
            if (n == 300)
            begin
                n_errors++;
                test_done();
            end
            check(64'(result), 64'(expect_of(x)));
        end
    endtask

    initial
    begin
        n_errors = 0;
        cmp_count = 0;
        rng = 32'hDB407A64;
        rst = 1'b1;
        go = 1'b0;
        frame_in = '0;
        f = '0;
        repeat (16) @(posedge sys_clk);
        #1 rst = 1'b0;
        check(64'({ready, busy, done, result}), 64'h4_0000_0000 << 2);
        for (int t = 0; t < 24; t++)
        begin
            for (int i = 0; i < 9; i++)
            begin
                rng = xs(rng);
                f.acf[i] = rng;
                rng = xs(rng);
                f.coef[i] = rng[15:0];
            end
            rng = xs(rng);
            // Reflections kept within half scale so a1 cannot overflow
            f.reflection_coefs = {rng[31], rng[31], rng[29:16], rng[15], rng[15], rng[13:0]};
            case (t)
                0: f.acf = '0;
                1: f.reflection_coefs = {16'h0CCD, 16'hB852};
                2: f.reflection_coefs = '0;
                3:
                begin
                    f.acf = {9{32'h7FFFFFFF}};
                    f.coef = {9{16'h7FFF}};
                end
                4:
                begin
                    f.acf = {9{32'h80000000}};
                    f.coef = {9{16'h8000}};
                end
                default: ;
            endcase
            // Partner sometimes slow to offer
            repeat (rng[1:0]) @(posedge sys_clk);
            // No gap wait makes the next offer early; frame 6 is always early
            #1 run(f, rng[2] && (t != 5));
        end
        test_done();
    end
endmodule // bep_top_tb
